// File: rtl/pfd_defs.svh
`ifndef PFD_DEFS_SVH
`define PFD_DEFS_SVH

// Register indices; byte address is four times the index
`define PFD_IDX_AIN_EN 8'hf2
`define PFD_IDX_P0_SEL 8'hf3
`define PFD_IDX_P1_SEL 8'hf4
`define PFD_IDX_P2_SEL 8'hf5
`define PFD_IDX_P0_DIR 8'hfd
`define PFD_IDX_P1_DIR 8'hfe
`define PFD_IDX_P2_DIR 8'hff

// Reset values
`define PFD_RST_AIN_EN 8'h00
`define PFD_RST_P0_SEL 8'h00
`define PFD_RST_P1_SEL 8'h00
`define PFD_RST_P2_SEL 8'h00
`define PFD_RST_P0_DIR 8'h00
`define PFD_RST_P1_DIR 8'h00
`define PFD_RST_P2_DIR 8'h00

// Writable bits of the mixed registers
`define PFD_MASK_P2_SEL 8'h7f
`define PFD_MASK_P2_DIR 8'hdf

// Fields of port2_function_and_priority
`define PFD_P2S_S0_S1 6
`define PFD_P2S_S1_T3 5
`define PFD_P2S_T1_T4 4
`define PFD_P2S_T1_S0 3
`define PFD_P2S_PIN4 2
`define PFD_P2S_PIN3 1
`define PFD_P2S_PIN0 0

// Fields of port2_direction_and_priority
`define PFD_P2D_PRI_HI 7
`define PFD_P2D_PRI_LO 6
`define PFD_P2D_DIR_HI 4

// Peripheral slots in claim and owner vectors
`define PFD_PER_S0 0
`define PFD_PER_S1 1
`define PFD_PER_T1 2
`define PFD_PER_T3 3
`define PFD_PER_T4 4
`define PFD_NUM_PER 5

`endif

// File: rtl/pfd_pkg.sv
`default_nettype none
package pfd_pkg;

  typedef enum logic [1:0] {
    PFD_BUS_IDLE = 2'b01,
    PFD_BUS_RESP = 2'b10
  } pfd_bus_state_t;

  typedef enum logic [1:0] {
    PFD_P0_S0_OVER_S1 = 2'b00,
    PFD_P0_S1_OVER_S0 = 2'b01,
    PFD_P0_T1_OVER_S1 = 2'b10,
    PFD_P0_T1_OVER_S0 = 2'b11
  } pfd_p0_prio_t;

  typedef struct packed {
    pfd_bus_state_t bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] ain_en;
    logic [7:0] p0_sel;
    logic [7:0] p1_sel;
    logic [7:0] p2_sel;
    logic [7:0] p0_dir;
    logic [7:0] p1_dir;
    logic [7:0] p2_dir;
    logic [7:0] ain_route;
    logic [7:0] p0_periph;
    logic [7:0] p1_periph;
    logic [4:0] p2_periph;
    logic [7:0] p0_drive;
    logic [7:0] p1_drive;
    logic [4:0] p2_drive;
    logic [4:0] p0_owner;
    logic [4:0] p1_owner;
  } pfd_state_t;

endpackage
`default_nettype wire

// File: rtl/pfd_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pfd_arb_if;
  logic [4:0] p0_claim;
  logic [4:0] p1_claim;
  logic [1:0] p0_peripheral_priority;
  logic [3:0] p1_priority;
  logic [4:0] p0_grant;
  logic [4:0] p1_grant;

  modport ctrl (
    output p0_claim,
    output p1_claim,
    output p0_peripheral_priority,
    output p1_priority,
    input p0_grant,
    input p1_grant
  );

  modport arb (
    input p0_claim,
    input p1_claim,
    input p0_peripheral_priority,
    input p1_priority,
    output p0_grant,
    output p1_grant
  );
endinterface
`default_nettype wire

// File: rtl/pfd_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pfd_pin_cell #(
  parameter int W = 8
) (
  input wire logic [W-1:0] sel_in,
  input wire logic [W-1:0] dir_in,
  input wire logic [W-1:0] analog_in,
  output logic [W-1:0] periph_out,
  output logic [W-1:0] drive_out
);
  // Analogue pins drop both the peripheral and the output driver
  always_comb begin
    periph_out = sel_in & ~analog_in;
    drive_out = dir_in & ~analog_in;
  end
endmodule
`default_nettype wire

// File: rtl/pfd_prio_arb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfd_defs.svh"
module pfd_prio_arb
  import pfd_pkg::*;
(
  pfd_arb_if.arb bus
);
  localparam int N = `PFD_NUM_PER;

  // True when peripheral a keeps a shared pin against b
  function automatic logic beats1(input int a, input int b,
                                  input logic [3:0] pri);
    logic r;
    r = (a < b);
    if ((a == `PFD_PER_S0 && b == `PFD_PER_S1) ||
        (a == `PFD_PER_S1 && b == `PFD_PER_S0)) begin
      r = (a == `PFD_PER_S1) == pri[3];
    end else if ((a == `PFD_PER_S1 && b == `PFD_PER_T3) ||
                 (a == `PFD_PER_T3 && b == `PFD_PER_S1)) begin
      r = (a == `PFD_PER_T3) == pri[2];
    end else if ((a == `PFD_PER_T1 && b == `PFD_PER_T4) ||
                 (a == `PFD_PER_T4 && b == `PFD_PER_T1)) begin
      r = (a == `PFD_PER_T4) == pri[1];
    end else if ((a == `PFD_PER_S0 && b == `PFD_PER_T1) ||
                 (a == `PFD_PER_T1 && b == `PFD_PER_S0)) begin
      r = (a == `PFD_PER_T1) == pri[0];
    end
    return r;
  endfunction

  function automatic logic beats0(input int a, input int b,
                                  input logic [1:0] pri);
    logic r;
    r = (a < b);
    case (pri)
      PFD_P0_S1_OVER_S0: begin
        if (a == `PFD_PER_S1 && b == `PFD_PER_S0) r = 1'b1;
        if (a == `PFD_PER_S0 && b == `PFD_PER_S1) r = 1'b0;
      end
      PFD_P0_T1_OVER_S1: begin
        if (a == `PFD_PER_T1 && b == `PFD_PER_S1) r = 1'b1;
        if (a == `PFD_PER_S1 && b == `PFD_PER_T1) r = 1'b0;
      end
      PFD_P0_T1_OVER_S0: begin
        if (a == `PFD_PER_T1 && b == `PFD_PER_S0) r = 1'b1;
        if (a == `PFD_PER_S0 && b == `PFD_PER_T1) r = 1'b0;
      end
      default: begin
        r = (a < b);
      end
    endcase
    return r;
  endfunction

  logic [N-1:0] win0;
  logic [N-1:0] win1;

  // Cyclic settings may leave no winner; the lowest winning slot keeps one owner
  always_comb begin
    win0 = '0;
    win1 = '0;
    bus.p0_grant = '0;
    bus.p1_grant = '0;
    for (int i = 0; i < N; i++) begin
      win0[i] = bus.p0_claim[i];
      win1[i] = bus.p1_claim[i];
      for (int j = 0; j < N; j++) begin
        if (j != i && bus.p0_claim[j] &&
            !beats0(i, j, bus.p0_peripheral_priority)) begin
          win0[i] = 1'b0;
        end
        if (j != i && bus.p1_claim[j] &&
            !beats1(i, j, bus.p1_priority)) begin
          win1[i] = 1'b0;
        end
      end
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (win0[i]) begin
        bus.p0_grant = 5'h01 << i;
      end
      if (win1[i]) begin
        bus.p1_grant = 5'h01 << i;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/pfd_port_cfg.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfd_defs.svh"
// Overview of operation
// - Analogue bit n routes port 0 pin n to converter input n; reset 0.
// - Select bit 0 is general I/O, 1 peripheral; port 2 has pins 4, 3, 0.
// - Port 2 function bit 6 picks serial 0 (0) or serial 1 (1) on port 1.
// - Bit 5 picks serial 1 (0) or timer 3 (1) on shared port 1 pins.
// - Bit 4 picks timer 1 (0) or timer 4 (1) on shared port 1 pins.
// - Bit 3 picks serial 0 (0) or timer 1 (1) on shared port 1 pins.
// - Port 2 direction bits 7:6 order the peripherals sharing port 0 pins.
// - Port 0 and 1 direction bits: 0 input, 1 output; reset all inputs.
// - Port 2 direction bits 4:0 set pins 4..0 direction; reset to inputs.
// - Enabled analogue input overrides port 0 function select of that pin.
module pfd_port_cfg
  import pfd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [4:0] p0_claim_in,
  input wire logic [4:0] p1_claim_in,
  output logic [7:0] analog_input_channel_out,
  output logic [7:0] p0_periph_out,
  output logic [7:0] p1_periph_out,
  output logic [4:0] p2_periph_out,
  output logic [7:0] p0_drive_out,
  output logic [7:0] p1_drive_out,
  output logic [4:0] p2_drive_out,
  output logic [4:0] p0_owner_out,
  output logic [4:0] p1_owner_out
);

  pfd_state_t cur;
  pfd_state_t next_cur;

  pfd_arb_if arb_bus ();

  logic [7:0] p0_per_c;
  logic [7:0] p1_per_c;
  logic [4:0] p2_per_c;
  logic [7:0] p0_drv_c;
  logic [7:0] p1_drv_c;
  logic [4:0] p2_drv_c;
  logic [4:0] p2_sel_pins;

  logic [9:0] reg_idx;
  logic addr_ok;
  logic addr_hit;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic commit_wr;

  // Register index decode; misaligned or unknown addresses answer error
  always_comb begin
    reg_idx = paddr_in[11:2];
    addr_ok = (paddr_in[1:0] == 2'b00);
    addr_hit = 1'b1;
    rd_byte = 8'h00;
    case (reg_idx)
      {2'b00, `PFD_IDX_AIN_EN}: begin
        rd_byte = cur.ain_en;
      end
      {2'b00, `PFD_IDX_P0_SEL}: begin
        rd_byte = cur.p0_sel;
      end
      {2'b00, `PFD_IDX_P1_SEL}: begin
        rd_byte = cur.p1_sel;
      end
      {2'b00, `PFD_IDX_P2_SEL}: begin
        rd_byte = cur.p2_sel & `PFD_MASK_P2_SEL;
      end
      {2'b00, `PFD_IDX_P0_DIR}: begin
        rd_byte = cur.p0_dir;
      end
      {2'b00, `PFD_IDX_P1_DIR}: begin
        rd_byte = cur.p1_dir;
      end
      {2'b00, `PFD_IDX_P2_DIR}: begin
        rd_byte = cur.p2_dir & `PFD_MASK_P2_DIR;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
    addr_hit = addr_hit & addr_ok;
  end

  // Write lands only at the edge where the master sees pready high
  always_comb begin
    wr_byte = pwdata_in[7:0];
    commit_wr = (cur.bus == PFD_BUS_RESP) && cur.pready && !cur.pslverr &&
                psel_in && penable_in && pwrite_in;
  end

  // Port 2 select bits sit at pins 4, 3 and 0 only
  always_comb begin
    p2_sel_pins = {cur.p2_sel[`PFD_P2S_PIN4], cur.p2_sel[`PFD_P2S_PIN3],
                   2'b00, cur.p2_sel[`PFD_P2S_PIN0]};
  end

  pfd_pin_cell #(
    .W(8)
  ) u_p0_cell (
    .sel_in(cur.p0_sel),
    .dir_in(cur.p0_dir),
    .analog_in(cur.ain_en),
    .periph_out(p0_per_c),
    .drive_out(p0_drv_c)
  );

  pfd_pin_cell #(
    .W(8)
  ) u_p1_cell (
    .sel_in(cur.p1_sel),
    .dir_in(cur.p1_dir),
    .analog_in(8'h00),
    .periph_out(p1_per_c),
    .drive_out(p1_drv_c)
  );

  pfd_pin_cell #(
    .W(5)
  ) u_p2_cell (
    .sel_in(p2_sel_pins),
    .dir_in(cur.p2_dir[`PFD_P2D_DIR_HI:0]),
    .analog_in(5'h00),
    .periph_out(p2_per_c),
    .drive_out(p2_drv_c)
  );

  // Claims come from the location select, which lives outside
  assign arb_bus.p0_claim = p0_claim_in;
  assign arb_bus.p1_claim = p1_claim_in;
  assign arb_bus.p0_peripheral_priority =
    cur.p2_dir[`PFD_P2D_PRI_HI:`PFD_P2D_PRI_LO];
  assign arb_bus.p1_priority = {cur.p2_sel[`PFD_P2S_S0_S1],
                                cur.p2_sel[`PFD_P2S_S1_T3],
                                cur.p2_sel[`PFD_P2S_T1_T4],
                                cur.p2_sel[`PFD_P2S_T1_S0]};

  pfd_prio_arb u_arb (
    .bus(arb_bus.arb)
  );

  always_comb begin
    next_cur = cur;

    // Bus handshake: one wait cycle, then pready for exactly one edge
    case (cur.bus)
      PFD_BUS_IDLE: begin
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;
        if (psel_in && penable_in) begin
          next_cur.bus = PFD_BUS_RESP;
          next_cur.pready = 1'b1;
          next_cur.pslverr = !addr_hit;
          next_cur.prdata = (!pwrite_in && addr_hit) ?
                            {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
      end
      PFD_BUS_RESP: begin
        next_cur.bus = PFD_BUS_IDLE;
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;
        next_cur.prdata = 32'h0000_0000;
      end
      default: begin
        next_cur.bus = PFD_BUS_IDLE;
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;
      end
    endcase

    if (commit_wr) begin
      case (reg_idx)
        {2'b00, `PFD_IDX_AIN_EN}: begin
          next_cur.ain_en = wr_byte;
        end
        {2'b00, `PFD_IDX_P0_SEL}: begin
          next_cur.p0_sel = wr_byte;
        end
        {2'b00, `PFD_IDX_P1_SEL}: begin
          next_cur.p1_sel = wr_byte;
        end
        {2'b00, `PFD_IDX_P2_SEL}: begin
          next_cur.p2_sel = wr_byte & `PFD_MASK_P2_SEL;
        end
        {2'b00, `PFD_IDX_P0_DIR}: begin
          next_cur.p0_dir = wr_byte;
        end
        {2'b00, `PFD_IDX_P1_DIR}: begin
          next_cur.p1_dir = wr_byte;
        end
        {2'b00, `PFD_IDX_P2_DIR}: begin
          next_cur.p2_dir = wr_byte & `PFD_MASK_P2_DIR;
        end
        default: begin
          next_cur.ain_en = cur.ain_en;
        end
      endcase
    end

    // Pin controls follow the stored settings one cycle later
    next_cur.ain_route = cur.ain_en;
    next_cur.p0_periph = p0_per_c;
    next_cur.p1_periph = p1_per_c;
    next_cur.p2_periph = p2_per_c;
    next_cur.p0_drive = p0_drv_c;
    next_cur.p1_drive = p1_drv_c;
    next_cur.p2_drive = p2_drv_c;
    next_cur.p0_owner = arb_bus.p0_grant;
    next_cur.p1_owner = arb_bus.p1_grant;

    if (rst_in) begin
      next_cur.bus = PFD_BUS_IDLE;
      next_cur.pready = 1'b0;
      next_cur.pslverr = 1'b0;
      next_cur.prdata = 32'h0000_0000;
      next_cur.ain_en = `PFD_RST_AIN_EN;
      next_cur.p0_sel = `PFD_RST_P0_SEL;
      next_cur.p1_sel = `PFD_RST_P1_SEL;
      next_cur.p2_sel = `PFD_RST_P2_SEL;
      next_cur.p0_dir = `PFD_RST_P0_DIR;
      next_cur.p1_dir = `PFD_RST_P1_DIR;
      next_cur.p2_dir = `PFD_RST_P2_DIR;
      next_cur.ain_route = 8'h00;
      next_cur.p0_periph = 8'h00;
      next_cur.p1_periph = 8'h00;
      next_cur.p2_periph = 5'h00;
      next_cur.p0_drive = 8'h00;
      next_cur.p1_drive = 8'h00;
      next_cur.p2_drive = 5'h00;
      next_cur.p0_owner = 5'h00;
      next_cur.p1_owner = 5'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    cur <= next_cur;
  end

  assign prdata_out = cur.prdata;
  assign pready_out = cur.pready;
  assign pslverr_out = cur.pslverr;
  assign analog_input_channel_out = cur.ain_route;
  assign p0_periph_out = cur.p0_periph;
  assign p1_periph_out = cur.p1_periph;
  assign p2_periph_out = cur.p2_periph;
  assign p0_drive_out = cur.p0_drive;
  assign p1_drive_out = cur.p1_drive;
  assign p2_drive_out = cur.p2_drive;
  assign p0_owner_out = cur.p0_owner;
  assign p1_owner_out = cur.p1_owner;

endmodule
`default_nettype wire

// File: sim/pfd_port_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pfd_port_cfg_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [4:0] p0_claim_in,
  input wire logic [4:0] p1_claim_in,
  input wire logic [7:0] analog_input_channel_out,
  input wire logic [7:0] p0_periph_out,
  input wire logic [7:0] p0_drive_out,
  input wire logic [4:0] p0_owner_out,
  input wire logic [4:0] p1_owner_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence acc_s;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence bad_addr_s;
    acc_s ##0 (paddr_in[1:0] != 2'b00);
  endsequence
  answer_one_wait_a: assert property (acc_s |=> pready_out)
    else $error("no answer after one wait");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  misaligned_refused_a: assert property (bad_addr_s |=>
    pslverr_out && prdata_out == 32'h0000_0000)
    else $error("misaligned access not refused");
  upper_read_zero_a: assert property (pready_out |->
    prdata_out[31:8] == 24'h00_0000) else $error("upper read bits set");
  analog_override_a: assert property (
    (analog_input_channel_out & (p0_periph_out | p0_drive_out)) == 8'h00)
    else $error("analogue pin still digital");
  single_owner_a: assert property (
    $onehot0(p0_owner_out) && $onehot0(p1_owner_out))
    else $error("more than one owner");
  owner_claimed_a: assert property (
    (p0_owner_out & ~$past(p0_claim_in)) == 5'h00 &&
    (p1_owner_out & ~$past(p1_claim_in)) == 5'h00)
    else $error("owner without claim");
  // Edge that still samples reset high clears owners despite a claim
  lone_p1_claim_a: assert property (
    !rst_in && $onehot(p1_claim_in) |=>
    p1_owner_out == $past(p1_claim_in))
    else $error("lone port 1 claim not granted");
  lone_p0_claim_a: assert property (
    !rst_in && $onehot(p0_claim_in) |=>
    p0_owner_out == $past(p0_claim_in))
    else $error("lone port 0 claim not granted");
  reset_clears_a: assert property ($fell(rst_in) |->
    !pready_out && analog_input_channel_out == 8'h00 &&
    p0_drive_out == 8'h00) else $error("outputs not cleared by reset");
endmodule
bind pfd_port_cfg pfd_port_cfg_checker chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .p0_claim_in(p0_claim_in), .p1_claim_in(p1_claim_in),
  .analog_input_channel_out(analog_input_channel_out),
  .p0_periph_out(p0_periph_out), .p0_drive_out(p0_drive_out),
  .p0_owner_out(p0_owner_out), .p1_owner_out(p1_owner_out)
);
`default_nettype wire

// File: sim/pfd_claim_model.sv
`timescale 1ns/1ps
`default_nettype none
// Peripherals settle their claims one edge after a location change
module pfd_claim_model (
  input wire logic clk_in,
  input wire logic [4:0] p0_want_in,
  input wire logic [4:0] p1_want_in,
  output var logic [4:0] p0_claim_out = 5'h00,
  output var logic [4:0] p1_claim_out = 5'h00
);
  always @(posedge clk_in) begin
    p0_claim_out <= p0_want_in;
    p1_claim_out <= p1_want_in;
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] p2s, p2d;
    logic [4:0] c0, c1, o0, o1;
  } pfd_row_t;
  logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, err_v;
  logic [7:0] rd_v, ain, p0p, p1p, p0d, p1d;
  logic [4:0] want0 = 5'h00, want1 = 5'h00, c0, c1, p2p, p2_drv, o0, o1;
  int fails = 0, n_tests = 0, cyc = 0;
  logic [7:0] regs [7] = '{8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hfd, 8'hfe, 8'hff};
  // Each row has at most two contenders per port, so every priority bit decides one row
  pfd_row_t rows [9] = '{
    '{8'h00, 8'h00, 5'h03, 5'h03, 5'h01, 5'h01},
    '{8'h40, 8'h40, 5'h03, 5'h03, 5'h02, 5'h02},
    '{8'h20, 8'h80, 5'h06, 5'h0a, 5'h04, 5'h08},
    '{8'h00, 8'hc0, 5'h05, 5'h0a, 5'h04, 5'h02},
    '{8'h10, 8'h00, 5'h00, 5'h14, 5'h00, 5'h10},
    '{8'h00, 8'h20, 5'h08, 5'h14, 5'h08, 5'h04},
    '{8'h88, 8'h1f, 5'h10, 5'h05, 5'h10, 5'h04},
    '{8'h87, 8'hff, 5'h00, 5'h05, 5'h00, 5'h01},
    '{8'h00, 8'h00, 5'h01, 5'h10, 5'h01, 5'h10}};

  pfd_claim_model model_u (.clk_in(clk_in), .p0_want_in(want0),
    .p1_want_in(want1), .p0_claim_out(c0), .p1_claim_out(c1));
  pfd_port_cfg dut_u (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .p0_claim_in(c0), .p1_claim_in(c1),
    .analog_input_channel_out(ain), .p0_periph_out(p0p),
    .p1_periph_out(p1p), .p2_periph_out(p2p), .p0_drive_out(p0d),
    .p1_drive_out(p1d), .p2_drive_out(p2_drv), .p0_owner_out(o0),
    .p1_owner_out(o1));

  always #2.5 clk_in = ~clk_in;

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One idle cycle after each transfer keeps strobes from being rewritten
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd_v = prdata[7:0];
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic summarize;
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    foreach (rows[i]) begin
      apb(1'b1, ba(8'hf5), rows[i].p2s);
      apb(1'b1, ba(8'hff), rows[i].p2d);
      want0 <= rows[i].c0;
      want1 <= rows[i].c1;
      repeat (4) @(posedge clk_in);
      chk("p0 owner", o0, rows[i].o0);
      chk("p1 owner", o1, rows[i].o1);
      chk("p2 drive", p2_drv, rows[i].p2d[4:0]);
      chk("p2 periph", p2p,
          {rows[i].p2s[2:1], 2'b00, rows[i].p2s[0]});
      apb(1'b0, ba(8'hf5), 8'h00);
      chk("p2 function reg", rd_v, rows[i].p2s & 8'h7f);
      apb(1'b0, ba(8'hff), 8'h00);
      chk("p2 direction reg", rd_v, rows[i].p2d & 8'hdf);
    end
    apb(1'b1, ba(8'hf2), 8'hff);
    apb(1'b1, ba(8'hf3), 8'hff);
    apb(1'b1, ba(8'hfd), 8'hff);
    apb(1'b1, ba(8'hf4), 8'h5a);
    apb(1'b1, ba(8'hfe), 8'ha5);
    repeat (3) @(posedge clk_in);
    chk("analog", ain, 8'hff);
    chk("p0 periph", p0p, 8'h00);
    chk("p0 drive", p0d, 8'h00);
    chk("p1 periph", p1p, 8'h5a);
    chk("p1 drive", p1d, 8'ha5);
    apb(1'b1, ba(8'hf2), 8'h0f);
    repeat (3) @(posedge clk_in);
    chk("analog", ain, 8'h0f);
    chk("p0 periph", p0p, 8'hf0);
    chk("p0 drive", p0d, 8'hf0);
    apb(1'b0, ba(8'hf6), 8'h00);
    chk("unmapped error", err_v, 1'b1);
    chk("unmapped data", rd_v, 8'h00);
    apb(1'b1, ba(8'hf3) + 12'h001, 8'h00);
    chk("misaligned error", err_v, 1'b1);
    apb(1'b0, ba(8'hf3), 8'h00);
    chk("p0 select kept", rd_v, 8'hff);
    rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk("drive after reset",
        {p0d, p1d, 3'b000, p2_drv}, 24'h00_0000);
    foreach (regs[i]) begin
      apb(1'b0, ba(regs[i]), 8'h00);
      chk("reset value", rd_v, 8'h00);
    end
    summarize();
  end
endmodule
`default_nettype wire
